// File: csi_core.sv
/*
  Shadow context save, return stack with error flags, and the two indirect pointers.
  Assumes all requests come from the instruction decoder on mclk; arst_n is power-on reset.
*/
// Notes on behaviour
// - interrupt entry copies context into shadows; return restores them
// - return stack holds sixteen fifteen-bit entries apart from data memory
// - push when full sets overflow flag, pop when empty sets underflow flag
// - with stack-error reset enabled, either stack error requests a software reset
// - two 16-bit pointers reach all data and program memory in one space
// - indirect access to program memory costs one extra instruction cycle
// - general purpose memory appears linearly across banks for sequential pointers
// - decoder supports 49 instructions, among them dedicated pointer operations
`timescale 1ns/10ps
module csi_core #(
  parameter int unsigned STK_DEPTH = csi_pkg::CSI_STK_DEPTH
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic irq_enter,
  input wire logic irq_return,
  input wire csi_pkg::csi_ctx_s ctx_live,
  output csi_pkg::csi_ctx_s ctx_restore,
  output logic ctx_restore_valid,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic [14:0] stk_push_addr,
  output logic [14:0] stk_top,
  output csi_pkg::csi_stk_flags_s stk_flags,
  input wire csi_pkg::csi_stk_flags_s stk_flag_clr,
  input wire logic stk_err_rst_en,
  output logic soft_rst_req,
  input wire logic ptr_req,
  input wire csi_pkg::csi_ptr_op_e ptr_op,
  input wire logic ptr_sel,
  input wire logic [5:0] ptr_k,
  input wire logic [15:0] ptr_wdata,
  output logic ptr_stall,
  output logic [15:0] ptr0,
  output logic [15:0] ptr1,
  output csi_pkg::csi_acc_s acc,
  output logic acc_valid
);
  import csi_pkg::*;
  localparam int unsigned CW = $clog2(STK_DEPTH + 1);
  localparam int unsigned IW = $clog2(STK_DEPTH);
  if (STK_DEPTH < 2 || STK_DEPTH > 256)
  begin : g_chk
    $error("csi_core: STK_DEPTH must lie in 2..256");
  end
  // linear window folds back onto the 80 general purpose bytes of each bank
  function automatic csi_acc_s csi_map(input logic [15:0] p);
    logic [15:0] l, bnk, off, a;
    csi_acc_s r;
    l = p - CSI_LIN_BASE;
    bnk = l / CSI_GPR_PER_BANK;
    off = l % CSI_GPR_PER_BANK;
    a = bnk * CSI_BANK_SIZE + CSI_GPR_OFS + off;
    r.prog = p[15];
    if (p[15])
      r.addr = p[14:0];
    else if (p >= CSI_LIN_BASE && p <= CSI_LIN_END)
      r.addr = a[14:0];
    else
      r.addr = {3'h0, p[11:0]};
    return r;
  endfunction
  // context shadows, pointers included
  csi_ctx_s shadow_reg, shadow_next;
  logic [15:0] sh_ptr0_reg, sh_ptr0_next, sh_ptr1_reg, sh_ptr1_next;
  logic restore_reg, restore_next;
  always_comb
  begin
    shadow_next = shadow_reg;
    sh_ptr0_next = sh_ptr0_reg;
    sh_ptr1_next = sh_ptr1_reg;
    restore_next = irq_return;
    if (irq_enter)
    begin
      shadow_next = ctx_live;
      sh_ptr0_next = ptr0;
      sh_ptr1_next = ptr1;
    end
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shadow_reg <= '0;
      sh_ptr0_reg <= CSI_PTR_RST;
      sh_ptr1_reg <= CSI_PTR_RST;
      restore_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      shadow_reg <= shadow_next;
      sh_ptr0_reg <= sh_ptr0_next;
      sh_ptr1_reg <= sh_ptr1_next;
      restore_reg <= restore_next;
    end
  end
  assign ctx_restore = shadow_reg;
  assign ctx_restore_valid = restore_reg;
  // return stack; push wins when push and pop coincide
  logic [14:0] stk_mem [STK_DEPTH];
  logic [CW-1:0] cnt_reg, cnt_next, idx_m2;
  logic [14:0] top_reg, top_next;
  csi_stk_flags_s flg_reg, flg_next;
  logic srst_reg, srst_next;
  logic full, ovf_ev, unf_ev, do_push;
  assign full = (cnt_reg == CW'(STK_DEPTH));
  assign ovf_ev = stk_push && full;
  assign unf_ev = stk_pop && !stk_push && (cnt_reg == '0);
  assign do_push = stk_push && !full;
  assign idx_m2 = cnt_reg - CW'(2);
  always_comb
  begin
    cnt_next = cnt_reg;
    top_next = top_reg;
    if (do_push)
    begin
      cnt_next = cnt_reg + CW'(1);
      top_next = stk_push_addr;
    end
    else if (stk_pop && !stk_push && cnt_reg != '0)
    begin
      cnt_next = cnt_reg - CW'(1);
      top_next = (cnt_reg >= CW'(2)) ? stk_mem[idx_m2[IW-1:0]] : CSI_STK_RST;
    end
    // setting beats a clear in the same cycle
    flg_next.ovf = (flg_reg.ovf && !stk_flag_clr.ovf) || ovf_ev;
    flg_next.unf = (flg_reg.unf && !stk_flag_clr.unf) || unf_ev;
    srst_next = stk_err_rst_en && (ovf_ev || unf_ev);
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= '0;
      top_reg <= CSI_STK_RST;
      flg_reg <= '0;
      srst_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_reg <= cnt_next;
      top_reg <= top_next;
      flg_reg <= flg_next;
      srst_reg <= srst_next;
    end
  end
  // storage array carries no reset, so a wide stack maps onto plain memory
  always_ff @(posedge mclk)
  begin
    if (clk_en && do_push)
      stk_mem[cnt_reg[IW-1:0]] <= stk_push_addr;
  end
  assign stk_top = top_reg;
  assign stk_flags = flg_reg;
  assign soft_rst_req = srst_reg;
  // indirect pointers
  csi_acc_st_e st_reg, st_next;
  logic [15:0] ptr0_reg, ptr0_next, ptr1_reg, ptr1_next;
  logic [15:0] cur, eff, upd, ksx;
  logic is_acc, wr_ptr, done;
  csi_acc_s map, acc_reg, acc_next;
  logic accv_reg, accv_next, lin_reg, lin_next;
  always_comb
  begin
    cur = ptr_sel ? ptr1_reg : ptr0_reg;
    ksx = {{10{ptr_k[5]}}, ptr_k};
    eff = cur;
    upd = cur;
    is_acc = 1'b1;
    wr_ptr = 1'b1;
    case (ptr_op)
      CSI_OP_LOAD:
      begin
        upd = ptr_wdata;
        is_acc = 1'b0;
      end
      CSI_OP_ADD:
      begin
        upd = cur + ksx;
        is_acc = 1'b0;
      end
      CSI_OP_OFFSET:
      begin
        eff = cur + ksx;
        wr_ptr = 1'b0;
      end
      CSI_OP_PREINC:
      begin
        eff = cur + 16'h0001;
        upd = eff;
      end
      CSI_OP_PREDEC:
      begin
        eff = cur - 16'h0001;
        upd = eff;
      end
      CSI_OP_POSTINC: upd = cur + 16'h0001;
      CSI_OP_POSTDEC: upd = cur - 16'h0001;
      default:
      begin
        is_acc = 1'b0;
        wr_ptr = 1'b0;
      end
    endcase
    map = csi_map(eff);
    // program words need a fetch cycle before the access can complete
    ptr_stall = ptr_req && is_acc && map.prog && (st_reg == CSI_ST_IDLE);
    done = ptr_req && !ptr_stall;
    st_next = ptr_stall ? CSI_ST_FETCH : CSI_ST_IDLE;
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    // return restores pointers and overrides a pointer update in that cycle
    if (irq_return)
    begin
      ptr0_next = sh_ptr0_reg;
      ptr1_next = sh_ptr1_reg;
    end
    else if (done && wr_ptr)
    begin
      if (ptr_sel)
        ptr1_next = upd;
      else
        ptr0_next = upd;
    end
    accv_next = done && is_acc;
    acc_next = (done && is_acc) ? map : acc_reg;
    lin_next = eff >= CSI_LIN_BASE && eff <= CSI_LIN_END;
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= CSI_ST_IDLE;
      ptr0_reg <= CSI_PTR_RST;
      ptr1_reg <= CSI_PTR_RST;
      acc_reg <= '0;
      accv_reg <= 1'b0;
      lin_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      acc_reg <= acc_next;
      accv_reg <= accv_next;
      lin_reg <= lin_next;
    end
  end
  assign ptr0 = ptr0_reg;
  assign ptr1 = ptr1_reg;
  assign acc = acc_reg;
  assign acc_valid = accv_reg;
  a_shadow_capture: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && irq_enter |=> shadow_reg == $past(ctx_live))
    else $error("shadow not captured on interrupt entry");
  a_restore_data: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && irq_return |=> ctx_restore_valid && ctx_restore == $past(shadow_reg))
    else $error("context restore missing");
  a_stack_bound: assert property (@(posedge mclk) disable iff (!arst_n)
    cnt_reg <= CW'(STK_DEPTH))
    else $error("stack count beyond depth");
  a_ovf_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && stk_push && full |=> stk_flags.ovf && cnt_reg == $past(cnt_reg))
    else $error("overflow not flagged");
  a_unf_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && unf_ev |=> stk_flags.unf && cnt_reg == '0)
    else $error("underflow not flagged");
  a_err_reset: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en |=> soft_rst_req == ($past(stk_err_rst_en) && ($past(ovf_ev) || $past(unf_ev))))
    else $error("software reset request wrong");
  a_ptr_load: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && done && ptr_op == CSI_OP_LOAD && !ptr_sel && !irq_return
    |=> ptr0 == $past(ptr_wdata))
    else $error("pointer load lost");
  a_prog_extra: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && ptr_stall |=> !acc_valid ##0 (!ptr_req || !ptr_stall))
    else $error("program fetch did not take one extra cycle");
  a_lin_window: assert property (@(posedge mclk) disable iff (!arst_n)
    acc_valid && lin_reg |-> !acc.prog && acc.addr[6:0] >= 7'h20 && acc.addr[6:0] <= 7'h6F)
    else $error("linear access outside general purpose bytes");
  a_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && stk_flags.ovf && !stk_flag_clr.ovf |=> stk_flags.ovf)
    else $error("overflow flag dropped");
  c_irq_round: cover property (@(posedge mclk) disable iff (!arst_n)
    irq_enter ##[1:20] irq_return);
  c_overflow: cover property (@(posedge mclk) disable iff (!arst_n) clk_en && ovf_ev);
  c_prog_fetch: cover property (@(posedge mclk) disable iff (!arst_n)
    clk_en && ptr_stall ##1 clk_en && ptr_req ##1 acc_valid);
  c_lin_access: cover property (@(posedge mclk) disable iff (!arst_n) acc_valid && lin_reg);
endmodule

// File: csi_pkg.sv
/*
  Shared constants and types for the CPU stack, shadow and pointer core.
  Assumes one instruction clock and that every request comes from logic on that clock.
*/
package csi_pkg;
  localparam int unsigned CSI_STK_DEPTH = 16;
  localparam int unsigned CSI_STK_W = 15;
  localparam int unsigned CSI_PTR_W = 16;
  localparam int unsigned CSI_NUM_INSTR = 49;
  localparam logic [15:0] CSI_LIN_BASE = 16'h2000;
  localparam logic [15:0] CSI_LIN_END = 16'h29AF;
  localparam logic [15:0] CSI_GPR_PER_BANK = 16'h0050;
  localparam logic [15:0] CSI_GPR_OFS = 16'h0020;
  localparam logic [15:0] CSI_BANK_SIZE = 16'h0080;
  localparam logic [15:0] CSI_PTR_RST = 16'h0000;
  localparam logic [14:0] CSI_STK_RST = 15'h0000;
  localparam int unsigned CSI_PROG_XTRA_CYC = 1;

  typedef enum logic [2:0]
  {
    CSI_OP_NONE = 3'h0,
    CSI_OP_LOAD = 3'h1,
    CSI_OP_ADD = 3'h2,
    CSI_OP_OFFSET = 3'h3,
    CSI_OP_PREINC = 3'h4,
    CSI_OP_PREDEC = 3'h5,
    CSI_OP_POSTINC = 3'h6,
    CSI_OP_POSTDEC = 3'h7
  } csi_ptr_op_e;

  typedef enum logic [0:0]
  {
    CSI_ST_IDLE = 1'b0,
    CSI_ST_FETCH = 1'b1
  } csi_acc_st_e;

  typedef struct packed
  {
    logic [7:0] w;
    logic [4:0] status;
    logic [4:0] bsr;
    logic [6:0] pclath;
  } csi_ctx_s;

  typedef struct packed
  {
    logic ovf;
    logic unf;
  } csi_stk_flags_s;

  typedef struct packed
  {
    logic prog;
    logic [14:0] addr;
  } csi_acc_s;
endpackage

// File: csi_tb.sv
/*
  Self-checking bench for csi_core: stack, shadow context and indirect pointers.
  Assumes the csi_pkg package is compiled first and a 40 MHz mclk.
*/
`timescale 1ns/10ps
module tb;
  import csi_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic irq_enter = 1'b0;
  logic irq_return = 1'b0;
  logic stk_push = 1'b0;
  logic stk_pop = 1'b0;
  logic stk_err_rst_en = 1'b1;
  logic ptr_req = 1'b0;
  logic ptr_sel = 1'b0;
  logic [14:0] stk_push_addr = 15'h0000;
  logic [5:0] ptr_k = 6'h00;
  logic [15:0] ptr_wdata = 16'h0000;
  csi_ptr_op_e ptr_op = CSI_OP_NONE;
  csi_ctx_s ctx_live = 25'h0000000;
  csi_stk_flags_s stk_flag_clr = 2'h0;
  csi_ctx_s ctx_restore;
  csi_stk_flags_s stk_flags;
  csi_acc_s acc;
  logic ctx_restore_valid, soft_rst_req, ptr_stall, acc_valid;
  logic [14:0] stk_top;
  logic [15:0] ptr0, ptr1;
  int mismatches = 0;
  int check_count = 0;
  int st;

  csi_core #(.STK_DEPTH(16)) dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .irq_enter(irq_enter), .irq_return(irq_return), .ctx_live(ctx_live),
    .ctx_restore(ctx_restore), .ctx_restore_valid(ctx_restore_valid),
    .stk_push(stk_push), .stk_pop(stk_pop), .stk_push_addr(stk_push_addr),
    .stk_top(stk_top), .stk_flags(stk_flags), .stk_flag_clr(stk_flag_clr),
    .stk_err_rst_en(stk_err_rst_en), .soft_rst_req(soft_rst_req), .ptr_req(ptr_req),
    .ptr_op(ptr_op), .ptr_sel(ptr_sel), .ptr_k(ptr_k), .ptr_wdata(ptr_wdata),
    .ptr_stall(ptr_stall), .ptr0(ptr0), .ptr1(ptr1), .acc(acc), .acc_valid(acc_valid));

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one stack request, taken at the second edge; returns at the next falling edge
  task stk(input logic pu, input logic po, input logic [14:0] a);
    @(posedge mclk);
    stk_push <= pu;
    stk_pop <= po;
    stk_push_addr <= a;
    @(posedge mclk);
    stk_push <= 1'b0;
    stk_pop <= 1'b0;
    @(negedge mclk);
  endtask

  // pointer request held while stalled; n counts the stall cycles
  task pr(input csi_ptr_op_e op, input logic s, input logic [15:0] d, input logic [5:0] k,
    output int n);
    n = 0;
    @(posedge mclk);
    ptr_req <= 1'b1;
    ptr_op <= op;
    ptr_k <= k;
    ptr_sel <= s;
    ptr_wdata <= d;
    @(negedge mclk);
    while (ptr_stall === 1'b1 && n < 4)
    begin
      n++;
      @(negedge mclk);
    end
    @(posedge mclk);
    ptr_req <= 1'b0;
    @(negedge mclk);
  endtask

  task test_stack;
    for (int i = 0; i < 16; i++)
    begin
      stk(1'b1, 1'b0, 15'h0100 + 15'(i));
      chk(stk_top, 15'h0100 + 15'(i));
    end
    stk(1'b1, 1'b0, 15'h7FFF);
    chk(stk_top, 15'h010F);
    chk(stk_flags, 2'h2);
    chk(soft_rst_req, 1'b1);
    @(negedge mclk);
    chk(soft_rst_req, 1'b0);
    chk(stk_flags, 2'h2);
    // a frozen core must ignore the pop
    @(posedge mclk);
    clk_en <= 1'b0;
    stk(1'b0, 1'b1, 15'h0000);
    @(posedge mclk);
    clk_en <= 1'b1;
    @(negedge mclk);
    chk(stk_top, 15'h010F);
    @(posedge mclk);
    stk_flag_clr <= 2'h2;
    @(posedge mclk);
    stk_flag_clr <= 2'h0;
    @(negedge mclk);
    chk(stk_flags, 2'h0);
    for (int i = 15; i > 0; i--)
    begin
      stk(1'b0, 1'b1, 15'h0000);
      chk(stk_top, 15'h0100 + 15'(i - 1));
    end
    stk(1'b0, 1'b1, 15'h0000);
    chk(stk_top, 15'h0000);
    chk(stk_flags, 2'h0);
    @(posedge mclk);
    stk_err_rst_en <= 1'b0;
    stk(1'b0, 1'b1, 15'h0000);
    chk(stk_flags, 2'h1);
    chk(soft_rst_req, 1'b0);
    // a clear that meets a fresh underflow loses to it
    @(posedge mclk);
    stk_err_rst_en <= 1'b1;
    stk_flag_clr <= 2'h1;
    stk_pop <= 1'b1;
    @(posedge mclk);
    stk_flag_clr <= 2'h0;
    stk_pop <= 1'b0;
    @(negedge mclk);
    chk(stk_flags, 2'h1);
    chk(soft_rst_req, 1'b1);
    stk(1'b1, 1'b1, 15'h0055);
    chk(stk_top, 15'h0055);
  endtask

  task test_ptr;
    pr(CSI_OP_LOAD, 1'b0, 16'h204F, 6'h00, st);
    chk({acc_valid, ptr0}, {1'b0, 16'h204F});
    pr(CSI_OP_LOAD, 1'b1, 16'h8005, 6'h00, st);
    chk(ptr1, 16'h8005);
    // last byte of the first bank, then the first of the next
    pr(CSI_OP_POSTINC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc}, {1'b1, 16'h006F});
    pr(CSI_OP_POSTINC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc}, {1'b1, 16'h00A0});
    chk(ptr0, 16'h2051);
    chk(st, 0);
    pr(CSI_OP_POSTINC, 1'b1, 16'h0000, 6'h00, st);
    chk(st, 1);
    chk({acc_valid, acc}, {1'b1, 16'h8005});
    chk(ptr1, 16'h8006);
  endtask

  task test_ctx;
    @(posedge mclk);
    ctx_live <= 25'h1ABCDEF;
    irq_enter <= 1'b1;
    @(posedge mclk);
    irq_enter <= 1'b0;
    ctx_live <= 25'h0123456;
    pr(CSI_OP_LOAD, 1'b0, 16'h1234, 6'h00, st);
    chk(ptr0, 16'h1234);
    @(posedge mclk);
    irq_return <= 1'b1;
    @(posedge mclk);
    irq_return <= 1'b0;
    @(negedge mclk);
    chk(ctx_restore_valid, 1'b1);
    chk(ctx_restore, 25'h1ABCDEF);
    chk(ptr0, 16'h2051);
    chk(ptr1, 16'h8006);
    @(negedge mclk);
    chk(ctx_restore_valid, 1'b0);
  endtask

  // the other pointer operations, then the top end of the linear window and the first address past it
  task test_ops;
    pr(CSI_OP_ADD, 1'b0, 16'h0000, 6'h3E, st);
    chk({acc_valid, ptr0}, {1'b0, 16'h204F});
    pr(CSI_OP_OFFSET, 1'b0, 16'h0000, 6'h01, st);
    chk({acc_valid, acc, ptr0}, {1'b1, 16'h00A0, 16'h204F});
    pr(CSI_OP_PREINC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc, ptr0}, {1'b1, 16'h00A0, 16'h2050});
    pr(CSI_OP_PREDEC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc, ptr0}, {1'b1, 16'h006F, 16'h204F});
    pr(CSI_OP_POSTDEC, 1'b1, 16'h0000, 6'h00, st);
    chk({acc_valid, st[1:0], acc, ptr1}, {1'b1, 2'h1, 16'h8006, 16'h8005});
    pr(CSI_OP_LOAD, 1'b0, 16'h29AF, 6'h00, st);
    pr(CSI_OP_POSTINC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc}, {1'b1, 16'h0F6F});
    pr(CSI_OP_POSTINC, 1'b0, 16'h0000, 6'h00, st);
    chk({acc_valid, acc}, {1'b1, 16'h09B0});
    pr(CSI_OP_NONE, 1'b1, 16'h0000, 6'h00, st);
    chk({acc_valid, ptr0, ptr1}, {1'b0, 16'h29B1, 16'h8005});
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk({stk_top, stk_flags, ptr0, acc_valid}, 34'h0);
    test_stack;
    test_ptr;
    test_ctx;
    test_ops;
    end_sim;
  end

  // whole run takes well under 300 cycles; 2000 leaves ample margin
  initial
  begin
    #50000;
    mismatches++;
    end_sim;
  end
endmodule
